// [shared/status_cmd_pkg.sv]
// constants for the servo status command unit
// assumes a framed command port in front of it and one 250 MHz clock
//
// Operation
// R01 - status clear resets masked status bits, then acks
// R02 - status bits stay set until cleared
// R03 - unmasked status bits are left unchanged
// R04 - events after last poll survive a clear
// R05 - bit 13 marks program completed
// R06 - poll answers ack, or status word if set
// R07 - frame without command number acts as poll
// R08 - status commands never answered busy
// R09 - fixed format poll always returns status word
// R10 - read io returns io word, servo-cycle refresh
// R11 - read internal status; only its clear clears
// R12 - buffer read returns length words from address
// R13 - host asks one to eight words per read
// R14 - code words read back with msb cleared
// R15 - codes below 64 never stored in program
`default_nettype none

package status_cmd_pkg;

  // ***************************************************************
  // widths and command codes
  // ***************************************************************
  localparam int WORD_W = 16;
  localparam int CODE_W = 8;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [CODE_W-1:0] code_t;

  localparam code_t POLL_CODE         = 8'h00;
  localparam code_t STATUS_CLEAR_CODE = 8'h01;
  localparam code_t BUFFER_READ_CODE  = 8'h06;
  localparam code_t READ_ISW_CODE     = 8'h14;
  localparam code_t READ_IO_CODE      = 8'h15;
  localparam code_t FIXED_POLL_CODE   = 8'h1b;
  localparam code_t PROGRAM_CODE_MIN  = 8'h40;

  // ***************************************************************
  // status fields, buffer limits and reset values
  // ***************************************************************
  localparam int    PROG_DONE_BIT  = 13;
  localparam word_t WORD_ZERO      = 16'h0000;
  localparam int    CODE_MSB       = 7;
  localparam int    READ_MAX_WORDS = 8;
  localparam int    LEN_W          = 4;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int SERVO_CYCLE_US    = 120;
  localparam int SERVO_CYCLE_CLKS  = (SERVO_CYCLE_US * 1000000) / CLK_PERIOD_PS;

endpackage

`default_nettype wire

// [core/servo_status_command_unit.sv]
// status command interpreter of the servo controller
// assumes a frame decoder delivering one command per cmd_valid pulse,
// a program loader writing the buffer, and raw io pins off-domain
`default_nettype none
`timescale 1ns/10ps

module servo_status_command_unit
  import status_cmd_pkg::*;
#(
  parameter int SERVO_CLKS = SERVO_CYCLE_CLKS,
  parameter int BUF_DEPTH  = 256,
  parameter int ADDR_W     = 8,
  parameter int IO_W       = WORD_W,
  parameter code_t ISW_CLEAR_CODE = 8'h08
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // command port
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_has_code,
  input  wire status_cmd_pkg::code_t cmd_code,
  input  wire status_cmd_pkg::word_t cmd_param0,
  input  wire status_cmd_pkg::word_t cmd_param1,
  output logic                       cmd_ready_r,
  // response port
  output logic                       rsp_valid_r,
  output logic                       rsp_ack_only_r,
  output status_cmd_pkg::word_t      rsp_data_r,
  output logic                       rsp_last_r,
  output logic                       cmd_unknown_r,
  // event sources
  input  wire status_cmd_pkg::word_t psw_event,
  input  wire logic                  prog_done,
  input  wire status_cmd_pkg::word_t isw_event,
  input  wire logic [IO_W-1:0]       io_pins,
  // program buffer load port
  input  wire logic                  buf_wr_en,
  input  wire logic [ADDR_W-1:0]     buf_wr_addr,
  input  wire status_cmd_pkg::word_t buf_wr_data,
  input  wire logic                  buf_wr_is_code,
  output logic                       buf_wr_reject_r,
  // status views
  output status_cmd_pkg::word_t      polling_status_word_r,
  output status_cmd_pkg::word_t      internal_status_word_r,
  output logic [IO_W-1:0]            io_state_word_r
);

  import status_cmd_pkg::*;

  // ***************************************************************
  // types and declarations
  // ***************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_STREAM} rsp_state_e;

  rsp_state_e          state_r;
  word_t               psw_live_r;
  word_t               psw_seen_r;
  word_t               psw_events;
  word_t               psw_now;
  logic                take;
  logic                is_poll;
  logic                is_clear;
  logic                is_isw_clear;
  logic [IO_W-1:0]     io_s1_r;
  logic [IO_W-1:0]     io_s2_r;
  logic [IO_W-1:0]     io_s3_r;
  logic [IO_W-1:0]     io_stable_r;
  logic [$clog2(SERVO_CLKS+1)-1:0] tick_cnt_r;
  logic                tick;
  word_t               buf_mem [BUF_DEPTH];
  logic                buf_code [BUF_DEPTH];
  logic [ADDR_W-1:0]   rd_addr_r;
  logic [LEN_W-1:0]    rd_left_r;
  logic [LEN_W-1:0]    req_len;
  logic                wr_ok;

  // strips the top bit of a stored command code on read
  function automatic word_t buf_read_word(input word_t w, input logic is_code);
    word_t r;
    r = w;
    if (is_code)
    begin
      r[CODE_MSB] = 1'b0;
    end
    return r;
  endfunction

  // decodes the effective command, a codeless frame being a poll
  function automatic code_t eff_code(input logic has_code, input code_t code);
    code_t c;
    c = has_code ? code : POLL_CODE;
    return c;
  endfunction

  // ***************************************************************
  // command acceptance and decode
  // ***************************************************************
  // accepted whenever idle, regardless of motion or program activity
  assign take         = cmd_valid && cmd_ready_r;                         // [R08]
  assign is_poll      = take && (eff_code(cmd_has_code, cmd_code) == POLL_CODE); // [R07]
  assign is_clear     = take && (eff_code(cmd_has_code, cmd_code) == STATUS_CLEAR_CODE);
  assign is_isw_clear = take && (eff_code(cmd_has_code, cmd_code) == ISW_CLEAR_CODE);

  // buffer read length, out-of-range requests clamped to the legal span
  always_comb
  begin
    req_len = cmd_param0[LEN_W-1:0];
    if (cmd_param0 == WORD_ZERO)
    begin
      req_len = LEN_W'(1);                                                // [R13]
    end
    else if (cmd_param0 > WORD_W'(READ_MAX_WORDS))
    begin
      req_len = LEN_W'(READ_MAX_WORDS);                                   // [R13]
    end
  end

  // ***************************************************************
  // polling status word, double buffered
  // ***************************************************************
  // event vector with program completion folded in
  always_comb
  begin
    psw_events = psw_event;
    if (prog_done)
    begin
      psw_events[PROG_DONE_BIT] = 1'b1;                                   // [R05]
    end
  end

  // word as a poll would report it this cycle
  assign psw_now = psw_seen_r | psw_live_r;

  // live half collects events since the last poll; a clear never
  // touches it, so fresh events reach the next poll
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      psw_live_r <= WORD_ZERO;
    end
    else if (is_poll || (take && cmd_code == FIXED_POLL_CODE && cmd_has_code))
    begin
      psw_live_r <= psw_events;                                           // [R04]
    end
    else
    begin
      psw_live_r <= psw_live_r | psw_events;                              // [R02]
    end
  end

  // seen half holds reported bits until masked off by a clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      psw_seen_r <= WORD_ZERO;
    end
    else if (is_poll || (take && cmd_code == FIXED_POLL_CODE && cmd_has_code))
    begin
      psw_seen_r <= psw_now;                                              // [R04]
    end
    else if (is_clear)
    begin
      psw_seen_r <= psw_seen_r & ~cmd_param0;                             // [R01] [R03]
    end
  end

  // visible copy of the combined word
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      polling_status_word_r <= WORD_ZERO;
    end
    else
    begin
      polling_status_word_r <= psw_now;
    end
  end

  // ***************************************************************
  // internal status word
  // ***************************************************************
  // sticky, cleared only by its own clear command; set wins
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      internal_status_word_r <= WORD_ZERO;
    end
    else if (is_isw_clear)
    begin
      internal_status_word_r <= isw_event;                                // [R11]
    end
    else
    begin
      internal_status_word_r <= internal_status_word_r | isw_event;       // [R11]
    end
  end

  // ***************************************************************
  // io state word, synchronised and refreshed each servo cycle
  // ***************************************************************
  // three-stage synchroniser and agreement filter
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      io_s1_r     <= '0;
      io_s2_r     <= '0;
      io_s3_r     <= '0;
      io_stable_r <= '0;
    end
    else
    begin
      io_s1_r <= io_pins;
      io_s2_r <= io_s1_r;
      io_s3_r <= io_s2_r;
      for (int i = 0; i < IO_W; i++)
      begin
        if (io_s2_r[i] == io_s3_r[i])
        begin
          io_stable_r[i] <= io_s3_r[i];
        end
      end
    end
  end

  // servo cycle tick
  assign tick = (tick_cnt_r == ($clog2(SERVO_CLKS+1))'(SERVO_CLKS - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      tick_cnt_r <= '0;
    end
    else if (tick)
    begin
      tick_cnt_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // io word refresh once per servo cycle
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      io_state_word_r <= '0;
    end
    else if (tick)
    begin
      io_state_word_r <= io_stable_r;                                     // [R10]
    end
  end

  // ***************************************************************
  // program buffer
  // ***************************************************************
  // host-only codes are refused as program content
  assign wr_ok = !(buf_wr_is_code && (buf_wr_data[CODE_W-1:0] < PROGRAM_CODE_MIN)); // [R15]

  always_ff @(posedge ref_clk)
  begin
    if (buf_wr_en && wr_ok)
    begin
      buf_mem[buf_wr_addr]  <= buf_wr_data;
      buf_code[buf_wr_addr] <= buf_wr_is_code;
    end
  end

  // rejected write flag, one cycle
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      buf_wr_reject_r <= 1'b0;
    end
    else
    begin
      buf_wr_reject_r <= buf_wr_en && !wr_ok;                             // [R15]
    end
  end

  // ***************************************************************
  // response sequencer
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_r        <= ST_IDLE;
      cmd_ready_r    <= 1'b0;
      rsp_valid_r    <= 1'b0;
      rsp_ack_only_r <= 1'b0;
      rsp_data_r     <= WORD_ZERO;
      rsp_last_r     <= 1'b0;
      cmd_unknown_r  <= 1'b0;
      rd_addr_r      <= '0;
      rd_left_r      <= '0;
    end
    else
    begin
      rsp_valid_r    <= 1'b0;
      rsp_ack_only_r <= 1'b0;
      rsp_last_r     <= 1'b0;
      cmd_unknown_r  <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          cmd_ready_r <= 1'b1;
          if (take)
          begin
            rsp_valid_r <= 1'b1;
            rsp_last_r  <= 1'b1;
            rsp_data_r  <= WORD_ZERO;
            case (eff_code(cmd_has_code, cmd_code))
              POLL_CODE:
              begin
                rsp_ack_only_r <= (psw_now == WORD_ZERO);                 // [R06]
                rsp_data_r     <= psw_now;                                // [R06]
              end
              FIXED_POLL_CODE:
              begin
                rsp_data_r <= psw_now;                                    // [R09]
              end
              STATUS_CLEAR_CODE:
              begin
                rsp_ack_only_r <= 1'b1;                                   // [R01]
              end
              READ_IO_CODE:
              begin
                rsp_data_r <= WORD_W'(io_state_word_r);                   // [R10]
              end
              READ_ISW_CODE:
              begin
                rsp_data_r <= internal_status_word_r;                     // [R11]
              end
              BUFFER_READ_CODE:
              begin
                rsp_valid_r <= 1'b0;
                rsp_last_r  <= 1'b0;
                rd_addr_r   <= cmd_param1[ADDR_W-1:0];                    // [R12]
                rd_left_r   <= req_len;                                   // [R12]
                cmd_ready_r <= 1'b0;
                state_r     <= ST_STREAM;
              end
              default:
              begin
                if (eff_code(cmd_has_code, cmd_code) == ISW_CLEAR_CODE)
                begin
                  rsp_ack_only_r <= 1'b1;
                end
                else
                begin
                  rsp_valid_r   <= 1'b0;
                  rsp_last_r    <= 1'b0;
                  cmd_unknown_r <= 1'b1;
                end
              end
            endcase
          end
        end
        ST_STREAM:
        begin
          // one buffer word per cycle, consecutive addresses
          rsp_valid_r <= 1'b1;
          rsp_data_r  <= buf_read_word(buf_mem[rd_addr_r], buf_code[rd_addr_r]); // [R12] [R14]
          rd_addr_r   <= rd_addr_r + 1'b1;                                // [R12]
          rd_left_r   <= rd_left_r - 1'b1;
          if (rd_left_r == LEN_W'(1))
          begin
            rsp_last_r  <= 1'b1;
            cmd_ready_r <= 1'b1;
            state_r     <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [verification/status_cmd_monitor.sv]
// assertions on the status command unit ports
// assumes the bind below and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module status_cmd_monitor
  import status_cmd_pkg::*;
#(
  parameter int    IO_W           = 16,
  parameter code_t ISW_CLEAR_CODE = 8'h08
)
(
  input wire logic                  ref_clk,
  input wire logic                  resetn,
  input wire logic                  cmd_valid,
  input wire logic                  cmd_has_code,
  input wire status_cmd_pkg::code_t cmd_code,
  input wire logic                  cmd_ready_r,
  input wire logic                  rsp_valid_r,
  input wire logic                  rsp_ack_only_r,
  input wire status_cmd_pkg::word_t rsp_data_r,
  input wire logic                  rsp_last_r,
  input wire logic                  buf_wr_en,
  input wire status_cmd_pkg::word_t buf_wr_data,
  input wire logic                  buf_wr_is_code,
  input wire logic                  buf_wr_reject_r,
  input wire status_cmd_pkg::word_t internal_status_word_r,
  input wire logic [IO_W-1:0]       io_state_word_r
);
  // ***************************************************************
  // properties
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic take;
  // command accepted at this edge
  assign take = cmd_valid && cmd_ready_r;
  a_poll_answer: assert property (take && (!cmd_has_code || cmd_code == POLL_CODE) |=>
    rsp_valid_r && rsp_last_r && (rsp_ack_only_r == (rsp_data_r == WORD_ZERO)))
    else $error("poll answer wrong");
  a_fixed_poll: assert property (take && cmd_has_code && cmd_code == FIXED_POLL_CODE |=>
    rsp_valid_r && !rsp_ack_only_r) else $error("fixed poll not formatted");
  a_clear_ack: assert property (take && cmd_has_code && cmd_code == STATUS_CLEAR_CODE |=>
    rsp_valid_r && rsp_ack_only_r && rsp_last_r) else $error("clear not acked");
  a_io_read: assert property (take && cmd_has_code && cmd_code == READ_IO_CODE |=>
    rsp_valid_r && rsp_data_r == $past(io_state_word_r)) else $error("io word wrong");
  a_isw_sticky: assert property (!(take && cmd_has_code && cmd_code == ISW_CLEAR_CODE) |=>
    ($past(internal_status_word_r) & ~internal_status_word_r) == WORD_ZERO)
    else $error("isw bit lost");
  a_buf_read: assert property (take && cmd_has_code && cmd_code == BUFFER_READ_CODE |=>
    !cmd_ready_r ##1 rsp_valid_r) else $error("buffer read timing");
  a_no_busy: assert property (rsp_last_r |-> cmd_ready_r) else $error("not ready after answer");
  a_code_reject: assert property (buf_wr_en && buf_wr_is_code &&
    buf_wr_data[7:0] < PROGRAM_CODE_MIN |=> buf_wr_reject_r) else $error("low code stored");
endmodule
bind servo_status_command_unit status_cmd_monitor #(.IO_W(IO_W), .ISW_CLEAR_CODE(ISW_CLEAR_CODE))
  i_mon (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
  .cmd_has_code(cmd_has_code), .cmd_code(cmd_code), .cmd_ready_r(cmd_ready_r),
  .rsp_valid_r(rsp_valid_r), .rsp_ack_only_r(rsp_ack_only_r), .rsp_data_r(rsp_data_r),
  .rsp_last_r(rsp_last_r), .buf_wr_en(buf_wr_en), .buf_wr_data(buf_wr_data),
  .buf_wr_is_code(buf_wr_is_code), .buf_wr_reject_r(buf_wr_reject_r),
  .internal_status_word_r(internal_status_word_r), .io_state_word_r(io_state_word_r));
`default_nettype wire

// [verification/host_cmd_model.sv]
// host side of the command port
// assumes requests are launched 1 ns after the clock edge
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model
  import status_cmd_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  cmd_ready_r,
  output logic                       cmd_valid,
  output logic                       cmd_has_code,
  output status_cmd_pkg::code_t      cmd_code,
  output status_cmd_pkg::word_t      cmd_param0,
  output status_cmd_pkg::word_t      cmd_param1
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_has_code = 1'b0;
    cmd_code = 8'h00;
    cmd_param0 = 16'h0000;
    cmd_param1 = 16'h0000;
  end
  // hold request until taken, then scramble released lines
  task automatic send(input logic hc, input code_t c, input word_t p0, input word_t p1,
                      output bit ok);
    int n;
    ok = 1'b0;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_has_code = hc;
    cmd_code = c;
    cmd_param0 = (c != BUFFER_READ_CODE) ? p0 : (p0 == 0) ? 16'h0001 :
                 (p0 > 8) ? 16'h0008 : p0;
    cmd_param1 = p1;
    for (n = 0; n < 50 && !ok; n++)
    begin
      ok = (cmd_ready_r === 1'b1);
      @(posedge ref_clk);
      #1;
    end
    cmd_valid = 1'b0;
    cmd_has_code = ~hc;
    cmd_code = ~c;
    cmd_param0 = ~p0;
    cmd_param1 = ~p1;
  endtask
endmodule
`default_nettype wire

// [verification/servo_status_command_unit_tb_top.sv]
// self-checking bench of the status command unit
// assumes host_cmd_model and the bound monitor
`timescale 1ns/10ps
`default_nettype none
module servo_status_command_unit_tb_top;
  import status_cmd_pkg::*;
  localparam int    SERVO_N = 20;
  localparam code_t ISW_CLR = 8'h08;
  logic  ref_clk = 1'b0;
  logic  resetn = 1'b0;
  logic  cmd_valid, cmd_has_code, cmd_ready_r, rsp_valid_r, rsp_ack_only_r, rsp_last_r;
  logic  cmd_unknown_r;
  logic  prog_done, buf_wr_en, buf_wr_is_code, got_ack;
  logic  [7:0] buf_wr_addr;
  code_t cmd_code;
  word_t cmd_param0, cmd_param1, rsp_data_r, psw_event, isw_event, io_pins, buf_wr_data;
  word_t psw_view;
  word_t got[$];
  word_t exp_buf[256];
  int    err_count = 0;
  int    num_checks = 0;
  // clock of 4 ns
  always #2 ref_clk = ~ref_clk;
  host_cmd_model i_host (.ref_clk(ref_clk), .cmd_ready_r(cmd_ready_r), .cmd_valid(cmd_valid),
    .cmd_has_code(cmd_has_code), .cmd_code(cmd_code), .cmd_param0(cmd_param0),
    .cmd_param1(cmd_param1));
  servo_status_command_unit #(.SERVO_CLKS(SERVO_N), .ISW_CLEAR_CODE(ISW_CLR)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_has_code(cmd_has_code),
    .cmd_code(cmd_code), .cmd_param0(cmd_param0), .cmd_param1(cmd_param1),
    .cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r), .rsp_ack_only_r(rsp_ack_only_r),
    .rsp_data_r(rsp_data_r), .rsp_last_r(rsp_last_r), .cmd_unknown_r(cmd_unknown_r),
    .psw_event(psw_event), .prog_done(prog_done), .isw_event(isw_event), .io_pins(io_pins),
    .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data),
    .buf_wr_is_code(buf_wr_is_code), .buf_wr_reject_r(), .polling_status_word_r(psw_view),
    .internal_status_word_r(), .io_state_word_r());
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input word_t seen, input word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // send one command and gather its answer words
  task automatic cmd(input logic hc, input code_t c, input word_t p0, input word_t p1);
    bit ok;
    int n;
    got = {};
    i_host.send(hc, c, p0, p1, ok);
    for (n = 0; n < 20 && ok; n++)
    begin
      if (rsp_valid_r === 1'b1)
      begin
        got.push_back(rsp_data_r);
        got_ack = rsp_ack_only_r;
        if (rsp_last_r === 1'b1) break;
      end
      @(posedge ref_clk);
      #1;
    end
    if (!ok || n == 20)
    begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic expect1(input word_t exp, input logic ack);
    chk((got.size() == 1) ? got[0] : ~exp, exp);
    chk({15'h0000, got_ack}, {15'h0000, ack});
  endtask
  // one-cycle event pulse
  task automatic pulse(input word_t pe, input logic pd, input word_t ie);
    @(posedge ref_clk);
    #1;
    psw_event = pe;
    prog_done = pd;
    isw_event = ie;
    @(posedge ref_clk);
    #1;
    psw_event = 16'h0000;
    prog_done = 1'b0;
    isw_event = 16'h0000;
  endtask
  function automatic word_t strip(input word_t d, input logic is_code);
    return is_code ? (d & 16'hff7f) : d;
  endfunction
  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial
  begin
    word_t e, n2, m, d;
    int i, k, ln;
    bit ok;
    {psw_event, isw_event, io_pins, buf_wr_data} = '0;
    {prog_done, buf_wr_en, buf_wr_is_code, buf_wr_addr} = '0;
    void'($urandom(95));
    repeat (5) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    cmd(1'b1, POLL_CODE, 0, 0);
    expect1(16'h0000, 1'b1);
    cmd(1'b0, 8'hff, 0, 0);
    expect1(16'h0000, 1'b1);
    cmd(1'b1, FIXED_POLL_CODE, 0, 0);
    expect1(16'h0000, 1'b0);
    $display("test idle_poll done");
    e = (word_t'($urandom()) & 16'hdfff) | 16'h0001;
    pulse(e, 1'b1, 16'h0000);
    cmd(1'b1, POLL_CODE, 0, 0);
    expect1(e | 16'h2000, 1'b0);
    cmd(1'b1, FIXED_POLL_CODE, 0, 0);
    expect1(e | 16'h2000, 1'b0);
    n2 = word_t'($urandom()) | 16'h0100;
    pulse(n2, 1'b0, 16'h0000);
    cmd(1'b1, STATUS_CLEAR_CODE, 16'hffff, 0);
    expect1(16'h0000, 1'b1);
    cmd(1'b1, POLL_CODE, 0, 0);
    expect1(n2, 1'b0);
    m = word_t'($urandom());
    cmd(1'b1, STATUS_CLEAR_CODE, m, 0);
    cmd(1'b1, POLL_CODE, 0, 0);
    expect1(n2 & ~m, (n2 & ~m) == 16'h0000);
    chk(psw_view, n2 & ~m);
    $display("test sticky_status done");
    io_pins = word_t'($urandom());
    repeat (2 * SERVO_N + 5) @(posedge ref_clk);
    #1;
    cmd(1'b1, READ_IO_CODE, 0, 0);
    expect1(io_pins, 1'b0);
    e = word_t'($urandom()) | 16'h0400;
    pulse(16'h0000, 1'b0, e);
    cmd(1'b1, STATUS_CLEAR_CODE, 16'hffff, 0);
    cmd(1'b1, READ_ISW_CODE, 0, 0);
    expect1(e, 1'b0);
    cmd(1'b1, ISW_CLR, 0, 0);
    cmd(1'b1, READ_ISW_CODE, 0, 0);
    chk(got[0], 16'h0000);
    // unsupported code is taken, flagged, and never answered
    i_host.send(1'b1, 8'h05, 0, 0, ok);
    chk({15'h0000, cmd_unknown_r}, 16'h0001);
    chk({15'h0000, rsp_valid_r}, 16'h0000);
    $display("test io_isw done");
    for (i = 0; i < 11; i++)
    begin
      d = word_t'($urandom());
      @(posedge ref_clk);
      #1;
      buf_wr_en = 1'b1;
      buf_wr_is_code = (i % 2 == 1) || (i == 10);
      buf_wr_addr = (i == 10) ? 8'hfb : 8'(8'hfb + i);
      buf_wr_data = (i == 10) ? 16'h0005 : buf_wr_is_code ? (d | 16'h0080) : d;
      if (i < 10) exp_buf[buf_wr_addr] = strip(d, buf_wr_is_code);
    end
    @(posedge ref_clk);
    #1;
    buf_wr_en = 1'b0;
    for (i = 0; i < 3; i++)
    begin
      ln = (i == 0) ? 8 : (i == 1) ? 3 : 12;
      cmd(1'b1, BUFFER_READ_CODE, 16'(ln), 16'h00fb + 16'(i));
      chk(word_t'(got.size()), (ln > 8) ? 16'h0008 : 16'(ln));
      for (k = 0; k < got.size(); k++)
        chk(got[k], exp_buf[8'(8'hfb + i + k)]);
    end
    $display("test buffer_read done");
    wrap_up();
  end
endmodule
`default_nettype wire
